// ### hdl/sasz_top.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "sasz_cfg.svh"
// How it works
// - each area input pair must be complementary; a mismatch on a used pair is an error
// - up to five input pairs choose one of at most thirty-two areas
// - area minus one has bit i set when normal input i is off
// - a changed input combination waits the configurable delay, thirty ms by default
// - active area number is shown on two seven-segment digits
// - object in active protection zone turns the zone one safety outputs off
// - object in a warning zone turns only that zone's alert output off
// - dual mode: first output pair follows zone one, second pair zone two
// - in dual mode no warning zone acts; both alert outputs stay off
// - two combinations: one protection plus two warnings, or two protections
// - alert outputs are driven independently of the safety outputs
// - encoder mode refuses muting and dual protection requests
// - encoder mode refuses a pattern write that sets none of the four patterns to encoder
// - usable area count is limited by the enabled functions, two to thirty-two
// - distance is half the speed of light times the echo time
// - sweep of 270 degrees in eighth-degree steps, each step checked

module sasz_top
   import sasz_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = `SASZ_CYC_PER_MS
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [4:0]  areaIn,
   input  wire logic [4:0]  areaInN,
   input  wire logic        echoValid,
   input  wire logic [15:0] echoTofPs,
   output logic             zone1SafetyOutA,
   output logic             zone1SafetyOutB,
   output logic             zone2SafetyOutA,
   output logic             zone2SafetyOutB,
   output logic             firstAlertOutput,
   output logic             secondAlertOutput,
   output logic      [6:0]  segTens,
   output logic      [6:0]  segOnes,
   output logic             irq
);

   // ****************************************
   // helper functions
   // ****************************************

   // pair count actually usable under the enabled functions
   function automatic logic [2:0] eff_count(input sasz_ctrl_s c);
      logic [2:0] lim;
      lim = `SASZ_MAX_PAIRS;
      if (c.dual) begin
         lim = `SASZ_DUAL_PAIRS;
      end else if (c.mute) begin
         lim = `SASZ_MUTE_PAIRS;
      end
      if (c.inCnt == 3'h0) begin
         return 3'h1;
      end
      return (c.inCnt > lim) ? lim : c.inCnt;
   endfunction

   function automatic logic [4:0] used_mask(input logic [2:0] n);
      logic [4:0] m;
      m = 5'h00;
      for (int i = 0; i < 5; i++) begin
         m[i] = (3'(i) < n);
      end
      return m;
   endfunction

   // echo time in ps to distance in mm, half the round trip
   function automatic logic [15:0] tof_to_mm(input logic [15:0] tPs);
      logic [47:0] prod;
      prod = {32'h0, tPs} * `SASZ_LIGHT_M_S;
      return 16'(prod / `SASZ_PS_MM_DIV);
   endfunction

   // active-high segments, bit order g f e d c b a
   function automatic logic [6:0] seg7(input logic [3:0] d);
      unique case (d)
         4'h0:    return 7'h3F;
         4'h1:    return 7'h06;
         4'h2:    return 7'h5B;
         4'h3:    return 7'h4F;
         4'h4:    return 7'h66;
         4'h5:    return 7'h6D;
         4'h6:    return 7'h7D;
         4'h7:    return 7'h07;
         4'h8:    return 7'h7F;
         4'h9:    return 7'h6F;
         default: return 7'h40;
      endcase
   endfunction

   // ****************************************
   // declarations
   // ****************************************
   localparam logic [11:0] LAST_STEP = 12'(`SASZ_SCAN_STEPS - 1);
   localparam logic [31:0] LAST_CYC  = 32'(CYC_PER_MS - 1);
   localparam logic [31:0] CTRL_RST  = `SASZ_CTRL_RST;

   sasz_ctrl_s   ctrl_ff;
   sasz_settle_e state_ff;
   sasz_scan_s   scan_ff;
   logic [9:0]   pinMeta_ff;
   logic [9:0]   pinSync_ff;
   logic [7:0]   encPat_ff;
   logic [4:0]   zoneIdx_ff;
   logic [15:0]  limTab_ff [3][32];
   logic [3:0]   irqStat_ff;
   logic [3:0]   irqMask_ff;
   logic [4:0]   activeArea_ff;
   logic [4:0]   candHeld_ff;
   logic [31:0]  cycCnt_ff;
   logic [7:0]   msCnt_ff;
   logic [11:0]  stepCnt_ff;
   logic [2:0]   hits_ff;
   logic [31:0]  prdata_ff;
   logic         irq_ff;
   logic [2:0]   effCnt;
   logic [4:0]   usedPairs;
   logic         pairErr;
   logic [4:0]   candArea;
   logic [15:0]  distMm;
   logic [2:0]   hitNow;
   logic         wrEn;
   logic         rdSetup;
   logic         mapped;
   logic         refuseEvt;
   logic         areaEvt;
   logic         tripEvt;
   logic [3:0]   nxt_irqStat;
   logic [5:0]   areaNum;

   // ****************************************
   // area input pairs
   // ****************************************

   // two-stage synchroniser, the first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta_ff <= 10'h000;
         pinSync_ff <= 10'h000;
      end else begin
         pinMeta_ff <= {areaInN, areaIn};
         pinSync_ff <= pinMeta_ff;
      end
   end

   // decode of the used pairs into an area index
   assign effCnt    = eff_count(ctrl_ff);
   assign usedPairs = used_mask(effCnt);
   assign pairErr   = |(~(pinSync_ff[4:0] ^ pinSync_ff[9:5]) & usedPairs);
   assign candArea  = ~pinSync_ff[4:0] & usedPairs;

   // ****************************************
   // settling of a new area
   // ****************************************

   // any change of the candidate restarts the wait, so glitches never switch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff      <= ST_IDLE;
         candHeld_ff   <= 5'h00;
         cycCnt_ff     <= 32'h0;
         msCnt_ff      <= 8'h00;
         activeArea_ff <= 5'h00;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               if (!pairErr && candArea != activeArea_ff) begin
                  state_ff    <= ST_WAIT;
                  candHeld_ff <= candArea;
                  cycCnt_ff   <= 32'h0;
                  msCnt_ff    <= 8'h00;
               end
            end
            ST_WAIT: begin
               if (pairErr || candArea == activeArea_ff) begin
                  state_ff <= ST_IDLE;
               end else if (candArea != candHeld_ff) begin
                  candHeld_ff <= candArea;
                  cycCnt_ff   <= 32'h0;
                  msCnt_ff    <= 8'h00;
               end else if (msCnt_ff >= ctrl_ff.dlyMs) begin
                  activeArea_ff <= candHeld_ff;
                  state_ff      <= ST_IDLE;
               end else if (cycCnt_ff == LAST_CYC) begin
                  cycCnt_ff <= 32'h0;
                  msCnt_ff  <= msCnt_ff + 8'h01;
               end else begin
                  cycCnt_ff <= cycCnt_ff + 32'h1;
               end
            end
         endcase
      end
   end

   assign areaEvt = (state_ff == ST_WAIT) && !pairErr && (candArea == candHeld_ff) &&
                    (candArea != activeArea_ff) && (msCnt_ff >= ctrl_ff.dlyMs);

   // ****************************************
   // sweep and zone evaluation
   // ****************************************

   // a zero limit means the zone is not configured in this area
   assign distMm    = tof_to_mm(echoTofPs);
   assign hitNow[0] = (limTab_ff[0][activeArea_ff] != 16'h0) && (distMm < limTab_ff[0][activeArea_ff]);
   assign hitNow[1] = (limTab_ff[1][activeArea_ff] != 16'h0) && (distMm < limTab_ff[1][activeArea_ff]);
   assign hitNow[2] = !ctrl_ff.dual && (limTab_ff[2][activeArea_ff] != 16'h0) &&
                      (distMm < limTab_ff[2][activeArea_ff]);

   // hits gather over one sweep and are judged at its last step
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stepCnt_ff <= 12'h000;
         hits_ff    <= 3'h0;
         scan_ff    <= '0;
      end else if (echoValid) begin
         if (stepCnt_ff == LAST_STEP) begin
            stepCnt_ff <= 12'h000;
            hits_ff    <= 3'h0;
            scan_ff    <= '{valid: 1'b1, hit: hits_ff | hitNow};
         end else begin
            stepCnt_ff <= stepCnt_ff + 12'h001;
            hits_ff    <= hits_ff | hitNow;
         end
      end
   end

   assign tripEvt = echoValid && (stepCnt_ff == LAST_STEP) && (hits_ff[0] | hitNow[0]);

   // ****************************************
   // switching and alert outputs
   // ****************************************

   // outputs stay off until the first full sweep has been judged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         zone1SafetyOutA <= 1'b0;
         zone1SafetyOutB <= 1'b0;
         zone2SafetyOutA <= 1'b0;
         zone2SafetyOutB <= 1'b0;
      end else begin
         zone1SafetyOutA <= scan_ff.valid && !scan_ff.hit[0] && !pairErr;
         zone1SafetyOutB <= scan_ff.valid && !scan_ff.hit[0] && !pairErr;
         zone2SafetyOutA <= ctrl_ff.dual && scan_ff.valid && !scan_ff.hit[1] && !pairErr;
         zone2SafetyOutB <= ctrl_ff.dual && scan_ff.valid && !scan_ff.hit[1] && !pairErr;
      end
   end

   // alerts ignore pair errors and protection state on purpose
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         firstAlertOutput  <= 1'b0;
         secondAlertOutput <= 1'b0;
      end else begin
         firstAlertOutput  <= !ctrl_ff.dual && scan_ff.valid && !scan_ff.hit[1];
         secondAlertOutput <= !ctrl_ff.dual && scan_ff.valid && !scan_ff.hit[2];
      end
   end

   // ****************************************
   // area display
   // ****************************************
   assign areaNum = {1'b0, activeArea_ff} + 6'h01;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         segTens <= 7'h00;
         segOnes <= 7'h00;
      end else begin
         segTens <= seg7(4'(areaNum / 6'h0A));
         segOnes <= seg7(4'(areaNum % 6'h0A));
      end
   end

   // ****************************************
   // register bus
   // ****************************************

   // zero wait states; read data is captured in the setup cycle
   assign wrEn    = psel && penable && pwrite && mapped;
   assign rdSetup = psel && !penable;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_ff;

   always_comb begin
      mapped = 1'b0;
      unique case (paddr)
         `SASZ_OFF_CTRL, `SASZ_OFF_STATUS, `SASZ_OFF_IRQ_STAT, `SASZ_OFF_IRQ_MASK, `SASZ_OFF_ENC_PAT,
         `SASZ_OFF_ZONE_IDX, `SASZ_OFF_LIM_P1, `SASZ_OFF_LIM_Z2, `SASZ_OFF_LIM_W2: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // refused pattern writes keep the old pattern, refused dual or mute requests clear those bits; both raise an event
   assign refuseEvt = wrEn && (((paddr == `SASZ_OFF_CTRL) && pwdata[`SASZ_CTRL_ENC] &&
                       (pwdata[`SASZ_CTRL_DUAL] || pwdata[`SASZ_CTRL_MUTE])) ||
                      ((paddr == `SASZ_OFF_ENC_PAT) && ctrl_ff.enc &&
                       !((pwdata[1:0] == `SASZ_PAT_ENCODER) || (pwdata[3:2] == `SASZ_PAT_ENCODER) ||
                         (pwdata[5:4] == `SASZ_PAT_ENCODER) || (pwdata[7:6] == `SASZ_PAT_ENCODER))));

   // control, pattern, zone index and interrupt mask registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff    <= '{dlyMs: CTRL_RST[`SASZ_CTRL_DLY_LSB +: 8], inCnt: CTRL_RST[`SASZ_CTRL_CNT_LSB +: 3],
                         mute: CTRL_RST[`SASZ_CTRL_MUTE], enc: CTRL_RST[`SASZ_CTRL_ENC], dual: CTRL_RST[`SASZ_CTRL_DUAL]};
         encPat_ff  <= `SASZ_ENC_PAT_RST;
         zoneIdx_ff <= 5'h00;
         irqMask_ff <= 4'h0;
      end else if (wrEn) begin
         if (paddr == `SASZ_OFF_CTRL) begin
            ctrl_ff.dlyMs <= pwdata[`SASZ_CTRL_DLY_LSB +: 8];
            ctrl_ff.inCnt <= pwdata[`SASZ_CTRL_CNT_LSB +: 3];
            ctrl_ff.enc   <= pwdata[`SASZ_CTRL_ENC];
            ctrl_ff.dual  <= pwdata[`SASZ_CTRL_DUAL] && !pwdata[`SASZ_CTRL_ENC];
            ctrl_ff.mute  <= pwdata[`SASZ_CTRL_MUTE] && !pwdata[`SASZ_CTRL_ENC];
         end
         if (paddr == `SASZ_OFF_ENC_PAT && !refuseEvt) begin
            encPat_ff <= pwdata[7:0];
         end
         if (paddr == `SASZ_OFF_ZONE_IDX) begin
            zoneIdx_ff <= pwdata[4:0];
         end
         if (paddr == `SASZ_OFF_IRQ_MASK) begin
            irqMask_ff <= pwdata[3:0];
         end
      end
   end

   // per-area zone limits in mm, reached through the zone index
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int k = 0; k < 3; k++) begin
            for (int a = 0; a < 32; a++) begin
               limTab_ff[k][a] <= 16'h0000;
            end
         end
      end else if (wrEn) begin
         if (paddr == `SASZ_OFF_LIM_P1) begin
            limTab_ff[0][zoneIdx_ff] <= pwdata[15:0];
         end
         if (paddr == `SASZ_OFF_LIM_Z2) begin
            limTab_ff[1][zoneIdx_ff] <= pwdata[15:0];
         end
         if (paddr == `SASZ_OFF_LIM_W2) begin
            limTab_ff[2][zoneIdx_ff] <= pwdata[15:0];
         end
      end
   end

   // read capture
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= 32'h0;
      end else if (rdSetup) begin
         unique case (paddr)
            `SASZ_OFF_CTRL:     prdata_ff <= {16'h0, ctrl_ff.dlyMs, 2'h0, ctrl_ff.inCnt,
                                              ctrl_ff.mute, ctrl_ff.enc, ctrl_ff.dual};
            `SASZ_OFF_STATUS:   prdata_ff <= {18'h0, effCnt, scan_ff.hit, scan_ff.valid,
                                              (state_ff == ST_WAIT), pairErr, activeArea_ff};
            `SASZ_OFF_IRQ_STAT: prdata_ff <= {28'h0, irqStat_ff};
            `SASZ_OFF_IRQ_MASK: prdata_ff <= {28'h0, irqMask_ff};
            `SASZ_OFF_ENC_PAT:  prdata_ff <= {24'h0, encPat_ff};
            `SASZ_OFF_ZONE_IDX: prdata_ff <= {27'h0, zoneIdx_ff};
            `SASZ_OFF_LIM_P1:   prdata_ff <= {16'h0, limTab_ff[0][zoneIdx_ff]};
            `SASZ_OFF_LIM_Z2:   prdata_ff <= {16'h0, limTab_ff[1][zoneIdx_ff]};
            `SASZ_OFF_LIM_W2:   prdata_ff <= {16'h0, limTab_ff[2][zoneIdx_ff]};
            default:            prdata_ff <= 32'h0;
         endcase
      end
   end

   // ****************************************
   // interrupts
   // ****************************************

   // a set in the clearing cycle wins; a lasting pair error cannot be cleared
   always_comb begin
      nxt_irqStat = irqStat_ff;
      if (wrEn && paddr == `SASZ_OFF_IRQ_STAT) begin
         nxt_irqStat = irqStat_ff & ~pwdata[3:0];
      end
      nxt_irqStat[`SASZ_IRQ_PAIR]   = nxt_irqStat[`SASZ_IRQ_PAIR] | pairErr;
      nxt_irqStat[`SASZ_IRQ_AREA]   = nxt_irqStat[`SASZ_IRQ_AREA] | areaEvt;
      nxt_irqStat[`SASZ_IRQ_TRIP]   = nxt_irqStat[`SASZ_IRQ_TRIP] | tripEvt;
      nxt_irqStat[`SASZ_IRQ_REFUSE] = nxt_irqStat[`SASZ_IRQ_REFUSE] | refuseEvt;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStat_ff <= 4'h0;
         irq_ff     <= 1'b0;
      end else begin
         irqStat_ff <= nxt_irqStat;
         irq_ff     <= |(nxt_irqStat & irqMask_ff);
      end
   end

   assign irq = irq_ff;

endmodule

// ### hdl/sasz_cfg.svh
`ifndef SASZ_CFG_SVH
`define SASZ_CFG_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SASZ_OFF_CTRL      8'h00
`define SASZ_OFF_STATUS    8'h04
`define SASZ_OFF_IRQ_STAT  8'h08
`define SASZ_OFF_IRQ_MASK  8'h0C
`define SASZ_OFF_ENC_PAT   8'h10
`define SASZ_OFF_ZONE_IDX  8'h14
`define SASZ_OFF_LIM_P1    8'h18
`define SASZ_OFF_LIM_Z2    8'h1C
`define SASZ_OFF_LIM_W2    8'h20

// ****************************************
// field positions and reset values
// ****************************************
`define SASZ_CTRL_DUAL     0
`define SASZ_CTRL_ENC      1
`define SASZ_CTRL_MUTE     2
`define SASZ_CTRL_CNT_LSB  3
`define SASZ_CTRL_DLY_LSB  8
`define SASZ_CTRL_RST      32'h00001E28
`define SASZ_ENC_PAT_RST   8'h02
`define SASZ_PAT_ENCODER   2'h2
`define SASZ_IRQ_PAIR      0
`define SASZ_IRQ_AREA      1
`define SASZ_IRQ_TRIP      2
`define SASZ_IRQ_REFUSE    3
`define SASZ_MAX_PAIRS     3'h5
`define SASZ_DUAL_PAIRS    3'h4
`define SASZ_MUTE_PAIRS    3'h1

// ****************************************
// timing and scan geometry
// ****************************************
`define SASZ_CLK_HZ        250000000
`define SASZ_CYC_PER_MS    (`SASZ_CLK_HZ / 1000)
`define SASZ_SCAN_DEG      270
`define SASZ_STEP_MDEG     125
`define SASZ_SCAN_STEPS    ((`SASZ_SCAN_DEG * 1000) / `SASZ_STEP_MDEG)
`define SASZ_LIGHT_M_S     48'd299792458
`define SASZ_PS_MM_DIV     48'd2000000000

`endif

// ### hdl/sasz_pkg.sv
package sasz_pkg;

   // software view of the control word
   typedef struct packed {
      logic [7:0] dlyMs;
      logic [2:0] inCnt;
      logic       mute;
      logic       enc;
      logic       dual;
   } sasz_ctrl_s;

   // result of one full sweep
   typedef struct packed {
      logic       valid;
      logic [2:0] hit;
   } sasz_scan_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b10
   } sasz_settle_e;

endpackage

// ### tb/sasz_checker.sv
`timescale 1ns/1ps
// ****
// port-level checks
// ****
module sasz_checker
   import sasz_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = 4
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [4:0] areaIn,
   input wire logic [4:0] areaInN,
   input wire logic       zone1SafetyOutA,
   input wire logic       zone1SafetyOutB,
   input wire logic       zone2SafetyOutA,
   input wire logic       zone2SafetyOutB,
   input wire logic       firstAlertOutput,
   input wire logic       secondAlertOutput,
   input wire logic [6:0] segTens,
   input wire logic [6:0] segOnes
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // four edges cover the two-flop synchroniser plus the output register
   sequence s_pair_bad;
      (areaIn[0] == areaInN[0]) [*4];
   endsequence
   // display moves; the reset release step itself is skipped
   sequence s_disp_moved;
      $changed(segOnes) && $past(rst_n, 2);
   endsequence
   a_pair_zone1_off: assert property (s_pair_bad |-> !zone1SafetyOutA && !zone1SafetyOutB)
      else $error("zone one on during pair error");
   a_pair_zone2_off: assert property (s_pair_bad |-> !zone2SafetyOutA && !zone2SafetyOutB)
      else $error("zone two on during pair error");
   a_zone1_twins: assert property (zone1SafetyOutA == zone1SafetyOutB)
      else $error("zone one outputs differ");
   a_zone2_twins: assert property (zone2SafetyOutA == zone2SafetyOutB)
      else $error("zone two outputs differ");
   a_dual_no_alert: assert property (zone2SafetyOutA |-> !firstAlertOutput && !secondAlertOutput)
      else $error("alert on with zone two active");
   a_tens_digit: assert property ($past(rst_n) |-> segTens inside {7'h3F, 7'h06, 7'h5B, 7'h4F})
      else $error("tens digit out of range");
   a_ones_digit: assert property ($past(rst_n) |-> segOnes inside {7'h3F, 7'h06, 7'h5B, 7'h4F,
      7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F}) else $error("ones digit not a numeral");
   a_area_cap: assert property (segTens == 7'h4F |-> segOnes inside {7'h3F, 7'h06, 7'h5B})
      else $error("area above thirty-two");
   a_area_settled: assert property (s_disp_moved |-> $past(areaIn, 1) == $past(areaIn, 2))
      else $error("area moved while pins unsettled");
endmodule
bind sasz_top sasz_checker #(.CYC_PER_MS(CYC_PER_MS)) chk_u (.clk, .rst_n, .areaIn, .areaInN, .zone1SafetyOutA,
   .zone1SafetyOutB, .zone2SafetyOutA, .zone2SafetyOutB, .firstAlertOutput, .secondAlertOutput, .segTens, .segOnes);

// ### tb/sasz_partner.sv
`timescale 1ns/1ps
// ****
// area controller and echo source
// ****
module sasz_partner (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [4:0]  areaNum,
   input  wire logic [4:0]  breakPair,
   input  wire logic        runSweep,
   input  wire logic        objNear,
   output logic      [4:0]  areaIn,
   output logic      [4:0]  areaInN,
   output logic             echoValid,
   output logic      [15:0] echoTofPs
);
   localparam logic [15:0] NEAR_PS = 16'h0D08; // about half a metre away
   // pins are levels; a broken pair copies the normal half, only on command
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         areaIn  <= 5'h1F;
         areaInN <= 5'h00;
      end else begin
         areaIn  <= ~areaNum;
         areaInN <= areaNum ^ breakPair;
      end
   end
   // one return per angular step; the data line toggles when no return is valid
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         echoValid <= 1'b0;
         echoTofPs <= 16'h0000;
      end else begin
         echoValid <= runSweep;
         echoTofPs <= runSweep ? (objNear ? NEAR_PS : 16'hFFFF) : ~echoTofPs;
      end
   end
endmodule

// ### tb/sasz_top_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin miscompares++; \
$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
// ****
// bench top
// ****
module sasz_top_bench
   import sasz_pkg::*;
();
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, rdErr;
   logic        echoValid, runSweep, objNear;
   logic        zone1SafetyOutA, zone1SafetyOutB, zone2SafetyOutA, zone2SafetyOutB;
   logic        firstAlertOutput, secondAlertOutput;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdData;
   logic [4:0]  areaIn, areaInN, areaNum, breakPair, a;
   logic [15:0] echoTofPs;
   logic [6:0]  segTens, segOnes;
   int          miscompares, checked, seed;
   localparam logic [6:0] DIG [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};

   sasz_top #(.CYC_PER_MS(4)) dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .areaIn, .areaInN, .echoValid, .echoTofPs, .zone1SafetyOutA, .zone1SafetyOutB,
      .zone2SafetyOutA, .zone2SafetyOutB, .firstAlertOutput, .secondAlertOutput, .segTens, .segOnes, .irq);
   sasz_partner part_u (.clk, .rst_n, .areaNum, .breakPair, .runSweep, .objNear, .areaIn, .areaInN,
      .echoValid, .echoTofPs);

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // one transfer, request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // new pin combination, then a fixed wait
   task automatic area(input logic [4:0] n, input int w);
      areaNum <= n;
      repeat (w) @(posedge clk);
   endtask

   // a full sweep is 2160 returns; outputs follow one edge after
   task automatic sweep(input logic near);
      objNear <= near;
      runSweep <= 1'b1;
      repeat (2160) @(posedge clk);
      runSweep <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // verdict in one place, for the main sequence and the watchdog alike
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // cut a hang short; the tests need about 11k cycles
   initial begin
      #(4 * 40000);
      miscompares++;
      tally_and_finish;
   end

   // main sequence
   initial begin
      seed = 32'hE265;
      miscompares = 0;
      checked = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      areaNum = 5'h00;
      breakPair = 5'h00;
      runSweep = 1'b0;
      objNear = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(0, 8'h00, 0);
      `CHK("ctrl", 32'h00001E28, rdData)
      apb(0, 8'h24, 0);
      `CHK("unmapped", 1'b1, rdErr)
      `CHK("ready", 1'b1, pready)
      `CHK("ones", 7'h06, segOnes)
      area(5'h1F, 110);
      apb(0, 8'h04, 0);
      `CHK("held", 5'h00, rdData[4:0])
      area(5'h1F, 20);
      apb(0, 8'h04, 0);
      `CHK("area32", 5'h1F, rdData[4:0])
      `CHK("tens", DIG[3], segTens)
      $display("test reset and delay done");
      apb(1, 8'h00, 32'h00000128);
      for (int i = 0; i < 8; i++) begin
         a = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($random(seed));
         area(a, 12);
         apb(0, 8'h04, 0);
         `CHK("area", a, rdData[4:0])
         `CHK("ones", DIG[(a + 1) % 10], segOnes)
      end
      apb(1, 8'h00, 32'h00000228);
      area(~a, 5);
      area(a, 20);
      apb(0, 8'h04, 0);
      `CHK("glitch", a, rdData[4:0])
      apb(1, 8'h00, 32'h0000022C);
      area(5'h03, 20);
      apb(0, 8'h04, 0);
      `CHK("mutearea", 5'h01, rdData[4:0])
      `CHK("mutecnt", 3'h1, rdData[13:11])
      $display("test area select done");
      apb(1, 8'h00, 32'h00000128);
      area(5'h04, 12);
      apb(1, 8'h14, 32'h00000004);
      apb(1, 8'h18, 32'h000003E8);
      sweep(0);
      `CHK("far", 4'hB, {zone1SafetyOutA, zone2SafetyOutA, firstAlertOutput, secondAlertOutput})
      sweep(1);
      `CHK("prot", 4'h3, {zone1SafetyOutB, zone2SafetyOutA, firstAlertOutput, secondAlertOutput})
      apb(1, 8'h18, 32'h00000000);
      apb(1, 8'h1C, 32'h000003E8);
      sweep(1);
      `CHK("warn", 4'h9, {zone1SafetyOutA, zone2SafetyOutA, firstAlertOutput, secondAlertOutput})
      apb(1, 8'h00, 32'h00000129);
      sweep(1);
      `CHK("dualnear", 4'h8, {zone1SafetyOutA, zone2SafetyOutB, firstAlertOutput, secondAlertOutput})
      sweep(0);
      `CHK("dualfar", 4'hC, {zone1SafetyOutA, zone2SafetyOutB, firstAlertOutput, secondAlertOutput})
      $display("test zones done");
      apb(1, 8'h0C, 32'h00000001);
      breakPair <= 5'h01;
      area(5'h06, 30);
      apb(0, 8'h04, 0);
      `CHK("pairerr", 1'b1, rdData[5])
      `CHK("frozen", 5'h04, rdData[4:0])
      `CHK("safeoff", 2'h0, {zone1SafetyOutA, zone2SafetyOutB})
      `CHK("irq", 1'b1, irq)
      breakPair <= 5'h00;
      area(5'h04, 10);
      apb(1, 8'h08, 32'h00000001);
      repeat (2) @(posedge clk);
      `CHK("irqclr", 1'b0, irq)
      $display("test pair error done");
      apb(1, 8'h00, 32'h00000127);
      apb(0, 8'h00, 0);
      `CHK("encctrl", 32'h00000122, rdData)
      apb(0, 8'h08, 0);
      `CHK("refuse", 1'b1, rdData[3])
      apb(1, 8'h10, 32'h00000055);
      apb(0, 8'h10, 0);
      `CHK("patrej", 32'h00000002, rdData)
      apb(1, 8'h10, 32'h00000006);
      apb(0, 8'h10, 0);
      `CHK("patok", 32'h00000006, rdData)
      $display("test encoder done");
      tally_and_finish;
   end
endmodule
